// >>> rtl/lcd_pkg.sv
// constants, field layout and carrier types of the segment/common lcd driver
// assumes a 4-bit cpu data bus with nibble-wide system registers
package lcd_pkg;
    localparam int COMS      = 8;
    localparam int COLS      = 56;
    localparam int RAM_WORDS = 112;
    localparam int ADDR_W    = 12;
    localparam int CNT_W     = 20;
    // display ram window and its upper half for backplanes five to eight
    localparam logic [11:0] RAM_BASE  = 12'h300;
    localparam logic [11:0] RAM_LAST  = 12'h36f;
    localparam logic [6:0]  HI_OFFSET = 7'h38;
    // system registers owned by this block
    localparam logic [11:0] RATE_ADDR = 12'h003;
    localparam logic [11:0] PUMP_ADDR = 12'h013;
    localparam logic [11:0] MODE_ADDR = 12'h014;
    localparam logic [11:0] BLNK_ADDR = 12'h01d;
    localparam logic [11:0] STAT_ADDR = 12'h01e;
    localparam int PUMP_BIT = 2;
    localparam int COMS_BIT = 2;
    localparam int BLNK_BIT = 3;
    // reset values
    localparam logic [1:0] COLSEL_RST = 2'h0;
    localparam logic       COMSEL_RST = 1'h0;
    localparam logic       BLANK_RST  = 1'h0;
    localparam logic       PUMP_RST   = 1'h1;
    localparam logic [2:0] RATE_RST   = 3'h0;
    // first columns handed over to port groups d and e
    localparam int COL_D_FIRST = 48;
    localparam int COL_E_FIRST = 52;
    localparam logic [2:0] LAST_PH8 = 3'h7;
    localparam logic [2:0] LAST_PH4 = 3'h3;
    // timing
    localparam int CLK_HZ   = 100_000_000;
    localparam int LF_HZ    = 32768;
    localparam int FRAME_HZ = 32;
    localparam int SYS_PHASE_DEF = CLK_HZ / (FRAME_HZ * COMS);
    localparam int LF_PHASE_DEF  = LF_HZ / (FRAME_HZ * COMS);

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [3:0]        wdata;
        logic              wr;
        logic              rd;
    } bus_req_t;

    typedef struct packed {
        logic [COMS-1:0] com;
        logic [COLS-1:0] drive_column_pad;
        logic [7:0]      col_port;
        logic [3:0]      com_port;
    } pads_t;
endpackage

// >>> rtl/lcd_segment_common_driver.sv
// lcd duty generator, dual-port display ram and mode registers
// assumes a cpu nibble bus on CLK and a free low-frequency oscillator pin
//
// Contract
// [R1] eight backplanes and fifty-six columns from one ram plus duty generator
// [R2] two drive modes: quarter duty and eighth duty
// [R3] scan reads ram on its own port, columns follow writes automatically
// [R4] cpu reads and writes display ram like ordinary memory
// [R5] column select field decides if columns 49-56 are ports
// [R6] backplane select bit decides if backplanes 5-8 are a port
// [R7] options 0,0 and 0,1 clock the scan from the low-frequency source
// [R8] under those options stop keeps scanning while base timer rate nonzero
// [R9] options 1,0 and 1,1 clock the scan from the system clock
// [R10] system clocked: stop turns display off, ram keeps contents
// [R11] display off drives every backplane and column low
// [R12] eighth duty: 300h+n-1 backplanes 1-4, 338h+n-1 backplanes 5-8
// [R13] quarter duty: 300h-337h hold columns 1-56, bits to backplanes 1-4
// [R14] column select 00 gives 56, 01 gives 52, 1x gives 48 columns
// [R15] backplane select 0 gives eight, 1 gives four backplanes
// [R16] blank bit 1 turns display off, 0 on
// [R17] pump disable bit forces all outputs to ground
// [R18] backplanes active one at a time in a 4 or 8 phase frame
// [R19] port-assigned pads get no waveform, their ram stays accessible
`timescale 1ns/1ps
module lcd_segment_common_driver #(
    parameter int SYS_PHASE_CYCLES = lcd_pkg::SYS_PHASE_DEF,
    parameter int LF_PHASE_EDGES   = lcd_pkg::LF_PHASE_DEF
) (
    // clock, reset, enable
    input  wire logic              CLK,
    input  wire logic              RESET_N,
    input  wire logic              CE,
    // factory timing option strap and low-frequency oscillator pin
    input  wire logic [1:0]        SYSTEM_TIMING_OPTION,
    input  wire logic              LOW_FREQ_SOURCE,
    // cpu stop mode level
    input  wire logic              STOP_MODE,
    // register bus
    input  wire lcd_pkg::bus_req_t BUS_REQ,
    output logic [3:0]             RDATA,
    // glass pads and port release flags
    output lcd_pkg::pads_t         PADS
);
    import lcd_pkg::*;

    typedef struct packed {
        logic [RAM_WORDS-1:0][3:0] ram;
        logic [1:0]       col_sel;
        logic             com_sel;
        logic             blank;
        logic             pump_off;
        logic [2:0]       rate;
        logic [1:0]       opt;
        logic             opt_ok;
        logic [2:0]       lf_sync;
        logic             lf_lvl;
        logic [2:0]       phase;
        logic [CNT_W-1:0] cnt;
        logic [3:0]       rdata;
        pads_t            pads;
    } state_t;

    state_t           s_q;
    state_t           s_d;
    logic [COLS-1:0]  seg_bit;
    logic [COLS-1:0]  col_free;
    logic             disp_on;
    logic             lf_rise;
    logic             tick;
    logic             step;
    logic             ram_hit;
    logic [6:0]       ram_idx;
    logic [CNT_W-1:0] phase_len;
    logic [2:0]       last_ph;

    // refuse counts the phase counter cannot hold
    if (SYS_PHASE_CYCLES < 1 || SYS_PHASE_CYCLES * 2 >= (1 << CNT_W)) begin : g_chk_sys
        $error("SYS_PHASE_CYCLES out of range");
    end
    if (LF_PHASE_EDGES < 1 || LF_PHASE_EDGES * 2 >= (1 << CNT_W)) begin : g_chk_lf
        $error("LF_PHASE_EDGES out of range");
    end

    // per column: pick the ram bit of the live backplane, mark port release
    for (genvar c = 0; c < COLS; c++) begin : g_col
        logic [3:0] lo;
        logic [3:0] hi;
        assign lo = s_q.ram[c];                                    // [R12] [R13]
        assign hi = s_q.ram[c + int'(HI_OFFSET)];                  // [R12]
        assign seg_bit[c] = s_q.phase[2] ? hi[s_q.phase[1:0]] : lo[s_q.phase[1:0]]; // [R3]
        assign col_free[c] = ((c >= COL_D_FIRST) && s_q.col_sel[1])
                           || ((c >= COL_E_FIRST) && (s_q.col_sel != 2'h0)); // [R5] [R14]
    end

    // bus decode of the display ram window
    assign ram_hit = (BUS_REQ.addr >= RAM_BASE) && (BUS_REQ.addr <= RAM_LAST);
    assign ram_idx = 7'(BUS_REQ.addr - RAM_BASE);

    // next state: strap, synchroniser, duty generator, pads, bus
    always_comb begin
        s_d = s_q;
        // strap is caught once after reset release, never under the reset itself
        if (!s_q.opt_ok) begin
            s_d.opt    = SYSTEM_TIMING_OPTION;
            s_d.opt_ok = 1'b1;
        end
        // pin passes three stages; a change counts when stages two and three agree
        s_d.lf_sync = {s_q.lf_sync[1:0], LOW_FREQ_SOURCE};
        lf_rise = 1'b0;
        if ((s_q.lf_sync[1] == s_q.lf_sync[2]) && (s_q.lf_sync[2] != s_q.lf_lvl)) begin
            s_d.lf_lvl = s_q.lf_sync[2];
            lf_rise    = s_q.lf_sync[2];
        end
        // low-frequency options step on rising oscillator edges, others on CLK
        tick = s_q.opt[1] ? 1'b1 : lf_rise;                       // [R7] [R9]
        phase_len = s_q.opt[1] ? CNT_W'(SYS_PHASE_CYCLES) : CNT_W'(LF_PHASE_EDGES);
        // quarter duty keeps the frame rate, so each phase lasts twice as long
        if (s_q.com_sel) begin
            phase_len = {phase_len[CNT_W-2:0], 1'b0};
        end
        last_ph = s_q.com_sel ? LAST_PH4 : LAST_PH8;              // [R2] [R15]
        // stop kills the display unless the oscillator stays up for the base timer
        disp_on = s_q.opt_ok && !s_q.blank && !s_q.pump_off       // [R16] [R17]
                && !(STOP_MODE && (s_q.opt[1] || (s_q.rate == 3'h0))); // [R8] [R10]
        step = 1'b0;
        if (!disp_on) begin
            // a frame restarts from backplane one when the display returns
            s_d.phase = 3'h0;
            s_d.cnt   = '0;
        end else if (tick) begin
            if (s_q.cnt >= phase_len - CNT_W'(1)) begin
                s_d.cnt = '0;
                step    = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + CNT_W'(1);
            end
        end
        if (step) begin
            s_d.phase = (s_q.phase >= last_ph) ? 3'h0 : s_q.phase + 3'h1; // [R18]
        end
        // pads: off or released means low, never a scan waveform
        s_d.pads.com = '0;
        s_d.pads.drive_column_pad = '0;
        if (disp_on) begin
            s_d.pads.com[s_q.phase] = 1'b1;                       // [R18] [R1]
            s_d.pads.drive_column_pad = seg_bit & ~col_free;                   // [R3] [R19] [R11]
            if (s_q.com_sel) begin
                s_d.pads.com[COMS-1:4] = 4'h0;                    // [R6] [R19]
            end
        end
        s_d.pads.col_port = col_free[COLS-1:COL_D_FIRST];         // [R5]
        s_d.pads.com_port = {4{s_q.com_sel}};                     // [R6]
        // cpu writes; mode changes only count while the pump is off
        if (BUS_REQ.wr) begin
            if (ram_hit) begin
                s_d.ram[ram_idx] = BUS_REQ.wdata;                 // [R4] [R19]
            end
            case (BUS_REQ.addr)
                MODE_ADDR: begin
                    if (s_q.pump_off) begin
                        s_d.col_sel = BUS_REQ.wdata[1:0];         // [R5] [R14]
                        s_d.com_sel = BUS_REQ.wdata[COMS_BIT];    // [R6] [R15]
                    end
                end
                PUMP_ADDR: s_d.pump_off = BUS_REQ.wdata[PUMP_BIT];
                BLNK_ADDR: s_d.blank    = BUS_REQ.wdata[BLNK_BIT];
                RATE_ADDR: s_d.rate     = BUS_REQ.wdata[2:0];
                default: ;
            endcase
        end
        // cpu reads answer in the next cycle only; unmapped reads give zero
        s_d.rdata = 4'h0;
        if (BUS_REQ.rd) begin
            if (ram_hit) begin
                s_d.rdata = s_q.ram[ram_idx];                     // [R4]
            end else begin
                case (BUS_REQ.addr)
                    PUMP_ADDR: s_d.rdata = {1'b0, s_q.pump_off, 2'h0};
                    BLNK_ADDR: s_d.rdata = {s_q.blank, 3'h0};
                    RATE_ADDR: s_d.rdata = {1'b0, s_q.rate};
                    STAT_ADDR: s_d.rdata = {disp_on, s_q.phase};
                    default:   s_d.rdata = 4'h0;
                endcase
            end
        end
    end

    // one register stage for the whole state; CE freezes everything
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_q          <= '0;
            s_q.col_sel  <= COLSEL_RST;
            s_q.com_sel  <= COMSEL_RST;
            s_q.blank    <= BLANK_RST;
            s_q.pump_off <= PUMP_RST;
            s_q.rate     <= RATE_RST;
        end else if (CE) begin
            s_q <= s_d;
        end
    end

    assign RDATA = s_q.rdata;
    assign PADS  = s_q.pads;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    a_off_pads_low: assert property (CE && !disp_on |=> PADS.com == '0 && PADS.drive_column_pad == '0) // [R11]
        else $error("pads not low while display off");
    a_pump_forces_gnd: assert property (CE && s_q.pump_off |=> PADS.com == '0) // [R17]
        else $error("backplane driven with pump off");
    a_blank_off: assert property (CE && s_q.opt_ok && s_q.blank |-> !disp_on) // [R16]
        else $error("display on while blanked");
    a_one_backplane: assert property ($onehot0(PADS.com)) // [R18]
        else $error("more than one backplane active");
    a_quarter_release: assert property (CE && s_q.com_sel |=> PADS.com[7:4] == 4'h0) // [R6]
        else $error("released backplane driven");
    a_col48_release: assert property (CE && s_q.col_sel[1] |=> PADS.drive_column_pad[55:48] == 8'h0) // [R14]
        else $error("released columns 49-56 driven");
    a_col52_release: assert property (CE && s_q.col_sel == 2'h1 |=> PADS.drive_column_pad[55:52] == 4'h0) // [R5]
        else $error("released columns 53-56 driven");
    a_sys_stop_off: assert property (CE && STOP_MODE && s_q.opt[1] |=> PADS.com == '0) // [R10]
        else $error("display alive in stop on system clock");
    a_lf_stop_scan: assert property (s_q.opt_ok && !s_q.opt[1] && STOP_MODE
        && s_q.rate != 3'h0 && !s_q.blank && !s_q.pump_off |-> disp_on) // [R8]
        else $error("display lost in stop with base timer running");
    a_lf_step_edge: assert property (step && !s_q.opt[1] |-> lf_rise) // [R7]
        else $error("scan stepped without oscillator edge");
    a_quarter_wrap: assert property (CE && step && s_q.com_sel && s_q.phase == 3'h3
        |=> s_q.phase == 3'h0) // [R2]
        else $error("quarter duty frame did not wrap after four phases");
    a_low_half_map: assert property (CE && disp_on && s_q.phase == 3'h1
        |=> PADS.drive_column_pad[0] == $past(s_q.ram[0][1])) // [R13]
        else $error("column one does not follow ram 300h");
    a_high_half_map: assert property (CE && disp_on && s_q.phase == 3'h5
        |=> PADS.drive_column_pad[0] == $past(s_q.ram[56][1])) // [R12]
        else $error("column one does not follow ram 338h");

    property p_ram_back;
        logic [ADDR_W-1:0] a;
        logic [3:0] d;
        (CE && BUS_REQ.wr && ram_hit, a = BUS_REQ.addr, d = BUS_REQ.wdata)
        ##1 (CE && BUS_REQ.rd && BUS_REQ.addr == a) |=> RDATA == d;
    endproperty
    a_ram_readback: assert property (p_ram_back) // [R4]
        else $error("display ram read differs from write");

    c_eighth_frame: cover property (step && !s_q.com_sel && s_q.phase == 3'h7);
    c_quarter_frame: cover property (step && s_q.com_sel && s_q.phase == 3'h3);
    c_stop_scanning: cover property (STOP_MODE && disp_on && step);
    c_mode_ignored: cover property (BUS_REQ.wr && BUS_REQ.addr == MODE_ADDR && !s_q.pump_off);
endmodule // lcd_segment_common_driver

// >>> testbench/lcd_glass_model.sv
// passive glass model: reports which backplane electrode is driven
// assumes the driver pads are registered on CLK
`timescale 1ns/1ps
module lcd_glass_model (
    // driver clock and pads
    input  wire logic           CLK,
    input  wire lcd_pkg::pads_t PADS,
    // electrode state seen by the glass
    output int                  lit_bp,
    output logic                overlap_q
);
    import lcd_pkg::*;
    initial overlap_q = 1'b0;
    // index of the live backplane, -1 when the glass is dark
    always_comb begin
        lit_bp = -1;
        for (int k = 0; k < COMS; k++)
            if (PADS.com[k]) lit_bp = k;
    end
    // two live backplanes at once would ghost every segment
    always @(posedge CLK) begin
        if ($countones(PADS.com) > 1) overlap_q <= 1'b1;
    end
endmodule // lcd_glass_model

// >>> testbench/test_lcd_segment_common_driver.sv
// self-checking bench for the lcd driver: register bus tasks and scan checks
// assumes short phase parameters so a whole frame fits in a few dozen cycles
`timescale 1ns/1ps
module test_lcd_segment_common_driver;
    import lcd_pkg::*;
    logic             CLK = 1'b0, RESET_N = 1'b0, CE = 1'b1, STOP_MODE = 1'b0;
    logic             LOW_FREQ_SOURCE = 1'b0, lf_run = 1'b0;
    logic [1:0]       SYSTEM_TIMING_OPTION = 2'h2;
    bus_req_t         BUS_REQ = '0;
    logic [3:0]       RDATA;
    pads_t            PADS;
    int               lit_bp, lf_cnt = 0, mismatches = 0, tests_run = 0;
    logic             overlap_q;
    logic [3:0]       shadow [RAM_WORDS];
    logic [7:0]       exp_port;

    always #5 CLK = ~CLK;
    // slow oscillator: one toggle every four system clocks while enabled
    always @(posedge CLK) begin
        lf_cnt <= lf_cnt + 1;
        if (lf_run && lf_cnt % 4 == 0) LOW_FREQ_SOURCE <= ~LOW_FREQ_SOURCE;
    end

    lcd_segment_common_driver #(.SYS_PHASE_CYCLES(4), .LF_PHASE_EDGES(2)) dut (
        .CLK(CLK), .RESET_N(RESET_N), .CE(CE), .SYSTEM_TIMING_OPTION(SYSTEM_TIMING_OPTION),
        .LOW_FREQ_SOURCE(LOW_FREQ_SOURCE), .STOP_MODE(STOP_MODE), .BUS_REQ(BUS_REQ),
        .RDATA(RDATA), .PADS(PADS));
    lcd_glass_model glass (.CLK(CLK), .PADS(PADS), .lit_bp(lit_bp), .overlap_q(overlap_q));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one-cycle strobes; the gap edge keeps back-to-back calls from colliding
    task automatic wr(input logic [11:0] a, input logic [3:0] d);
        @(posedge CLK);
        BUS_REQ <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge CLK);
        BUS_REQ <= '0;
    endtask
    task automatic rd_check(input logic [11:0] a, input logic [3:0] exp);
        @(posedge CLK);
        BUS_REQ <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
        @(posedge CLK);
        BUS_REQ <= '0;
        @(negedge CLK);
        check(128'(RDATA), 128'(exp), "read data");
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge CLK);
    endtask
    task automatic wait_bp(input int bp);
        int t;
        for (t = 0; t < 300 && lit_bp != bp; t++) @(negedge CLK);
        if (t == 300) begin
            mismatches++;
            $display("[ERR] %0t backplane %0d never came", $time, bp);
            end_of_test();
        end
    endtask
    // expected columns for phase p; columns past ncol are released and dark
    function automatic logic [COLS-1:0] exp_seg(input int p, input int ncol);
        logic [COLS-1:0] s;
        s = '0;
        for (int n = 0; n < ncol; n++)
            s[n] = p < 4 ? shadow[n][p] : shadow[int'(HI_OFFSET) + n][p - 4];
        return s;
    endfunction
    task automatic scan(input int nph, input int ncol);
        // let a write just made reach the pads before the first look
        settle(2);
        for (int p = 0; p < nph; p++) begin
            wait_bp(p);
            check(128'(PADS.com), 128'(8'h1 << p), "backplane");
            check(128'(PADS.drive_column_pad), 128'(exp_seg(p, ncol)), "columns");
        end
    endtask

    initial begin
        repeat (5) @(posedge CLK);
        RESET_N <= 1'b1;
        // ram as plain memory, registers at reset, dark glass
        for (int i = 0; i < RAM_WORDS; i++) begin
            shadow[i] = 4'((i * 7 + 3) % 16);
            wr(RAM_BASE + 12'(i), shadow[i]);
        end
        for (int i = 0; i < RAM_WORDS; i += 37) rd_check(RAM_BASE + 12'(i), shadow[i]);
        rd_check(RAM_LAST, shadow[RAM_WORDS-1]);
        rd_check(12'h200, 4'h0);
        rd_check(PUMP_ADDR, 4'h4);
        rd_check(BLNK_ADDR, 4'h0);
        rd_check(MODE_ADDR, 4'h0);
        check(128'(PADS), 128'h0, "pump off pads");
        $display("test ram_regs done");
        // eighth duty scan, then a live ram edit shows without cpu help
        wr(PUMP_ADDR, 4'h0);
        scan(8, COLS);
        shadow[3] = ~shadow[3];
        wr(RAM_BASE + 12'h3, shadow[3]);
        scan(8, COLS);
        check(128'(overlap_q), 128'h0, "overlap");
        $display("test scan8 done");
        // blanking and system clocked stop both darken the glass
        wr(BLNK_ADDR, 4'h8);
        settle(3);
        check(128'(PADS), 128'h0, "blank pads");
        rd_check(BLNK_ADDR, 4'h8);
        wr(BLNK_ADDR, 4'h0);
        STOP_MODE <= 1'b1;
        settle(3);
        check(128'(PADS), 128'h0, "stop pads");
        @(posedge CLK);
        STOP_MODE <= 1'b0;
        rd_check(RAM_BASE + 12'h5, shadow[5]);
        $display("test blank_stop done");
        // mode writes ignored while pump runs, then every column select
        wr(MODE_ADDR, 4'h7);
        settle(3);
        check(128'({PADS.col_port, PADS.com_port}), 128'h0, "ignored mode");
        for (int sel = 0; sel < 4; sel++) begin
            exp_port = sel[1] ? 8'hff : (sel[0] ? 8'hf0 : 8'h00);
            wr(PUMP_ADDR, 4'h4);
            wr(MODE_ADDR, 4'(sel) | 4'h4);
            wr(PUMP_ADDR, 4'h0);
            settle(3);
            check(128'(PADS.col_port), 128'(exp_port), "column ports");
            check(128'(PADS.com_port), 128'hf, "backplane ports");
        end
        scan(4, COL_D_FIRST);
        rd_check(RAM_BASE + 12'h37, shadow[55]);
        $display("test modes done");
        // low-frequency clocking: scan follows the slow source, survives stop
        @(posedge CLK);
        RESET_N <= 1'b0;
        SYSTEM_TIMING_OPTION <= 2'h0;
        settle(2);
        @(posedge CLK);
        RESET_N <= 1'b1;
        wr(RATE_ADDR, 4'h1);
        wr(PUMP_ADDR, 4'h0);
        settle(40);
        check(128'(lit_bp), 128'h0, "held without source");
        @(posedge CLK);
        lf_run <= 1'b1;
        STOP_MODE <= 1'b1;
        wait_bp(1);
        wait_bp(2);
        wr(RATE_ADDR, 4'h0);
        settle(3);
        check(128'(PADS), 128'h0, "stop rate zero");
        @(posedge CLK);
        STOP_MODE <= 1'b0;
        $display("test low_freq done");
        end_of_test();
    end
endmodule // test_lcd_segment_common_driver
